// file: hdl/sol_regs.svh
`ifndef SOL_REGS_SVH
`define SOL_REGS_SVH
// register byte offsets
`define SOL_OFF_STRAPS 8'h00
`define SOL_OFF_CTRL 8'h04
`define SOL_OFF_ADV 8'h08
`define SOL_OFF_MODE 8'h0C
`define SOL_OFF_PINCTL 8'h10
// straps word field positions
`define SOL_ST_ADDR_LSB 0
`define SOL_ST_BCAST_BIT 5
`define SOL_ST_MODE_LSB 8
`define SOL_ST_ISO_BIT 12
`define SOL_ST_SPEED_BIT 13
`define SOL_ST_DUPLEX_BIT 14
`define SOL_ST_ANEG_BIT 15
`define SOL_ST_NAND_BIT 16
`define SOL_ST_LOCKED_BIT 31
// control register bit positions
`define SOL_CTRL_DUPLEX_BIT 8
`define SOL_CTRL_ISO_BIT 10
`define SOL_CTRL_ANEG_BIT 12
`define SOL_CTRL_SPEED_BIT 13
// advertisement speed capability bits
`define SOL_ADV_100_LSB 7
`define SOL_ADV_10_LSB 5
// mode register: bit 9 makes address zero unique
`define SOL_MODE_UNIQUE_BIT 9
// strap code values
`define SOL_MODE_RMII 3'h1
`define SOL_MODE_B2B 3'h5
`define SOL_ADDR_HIGH 2'h0
// pin count of the strap group
`define SOL_PIN_COUNT 13
`endif

// file: hdl/sol_pkg.sv
package sol_pkg;
   typedef enum logic [1:0] {
      SOL_ST_RESET = 2'h0,
      SOL_ST_CAPTURE = 2'h1,
      SOL_ST_RUN = 2'h3
   } sol_phase_type;
   typedef enum logic [1:0] {
      SOL_MD_RMII = 2'h0,
      SOL_MD_B2B = 2'h1,
      SOL_MD_RSVD = 2'h2
   } sol_mode_type;
endpackage : sol_pkg

// file: hdl/sol_pin_cell.sv
module sol_pin_cell (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // direction and function value
   input wire logic drive_en,
   input wire logic func_val,
   // pad side
   output logic pad_o,
   output logic pad_oe
);
   typedef struct packed {
      logic o;
      logic oe;
   } sol_cell_type;
   sol_cell_type st_reg;
   sol_cell_type st_next;

   always_comb begin
      st_next.o = func_val;
      st_next.oe = drive_en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pad_o = st_reg.o;
   assign pad_oe = st_reg.oe;
endmodule : sol_pin_cell

// file: hdl/sol_strap_latch.sv
// Notes on behaviour
// [R1] capture all straps at reset release, hold
// [R2] straps are inputs in reset, outputs after
// [R3] address low bits from straps, default one
// [R4] upper two address bits always zero
// [R5] address zero broadcast unless bit nine set
// [R6] broadcast-disable strap high makes zero unique
// [R7] mode 001 RMII, 101 back-to-back, else reserved
// [R8] isolate strap loads control bit ten
// [R9] speed strap loads bit 13 and advertisement
// [R10] duplex strap loads control bit eight
// [R11] autoneg strap loads control bit twelve
// [R12] low NAND-tree strap enables test mode
// [R13] outside logic leaves strap pins undriven in reset
`include "sol_regs.svh"
module sol_strap_latch
   import sol_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // strap pad inputs, sampled on the second clock after reset release
   input wire logic [2:0] mgmt_addr_strap,
   input wire logic bcast_disable_strap,
   input wire logic [2:0] mode_strap,
   input wire logic iso_strap,
   input wire logic speed_strap,
   input wire logic duplex_strap,
   input wire logic autoneg_enable_strap,
   input wire logic nand_tree_strap_n,
   // normal function values for the shared pins
   input wire logic [12:0] pin_func_val,
   // pad outputs of the shared pins
   output logic [12:0] pin_o,
   output logic [12:0] pin_oe,
   // decoded configuration
   output logic [4:0] mgmt_addr,
   output logic addr0_broadcast,
   output logic [1:0] op_mode,
   output logic nand_tree_en,
   output logic strap_locked,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import sol_pkg::*;

   // register indices, so the bus decode compares words of one width
   localparam logic [5:0] idx_straps = 6'(`SOL_OFF_STRAPS >> 2);
   localparam logic [5:0] idx_ctrl = 6'(`SOL_OFF_CTRL >> 2);
   localparam logic [5:0] idx_adv = 6'(`SOL_OFF_ADV >> 2);
   localparam logic [5:0] idx_mode = 6'(`SOL_OFF_MODE >> 2);
   // bus response codes
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      sol_phase_type phase;
      logic [2:0] addr_lo;
      logic bcast_off;
      logic [2:0] mode_code;
      logic nand_n;
      // strap levels as captured, never written by software
      logic iso_cap;
      logic speed_cap;
      logic duplex_cap;
      logic aneg_cap;
      logic [15:0] ctrl;
      logic [15:0] adv;
      logic [15:0] mode_reg;
      logic [4:0] addr_out;
      logic bcast_out;
      sol_mode_type mode_out;
      logic nand_out;
      logic locked;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      // registered ready flags of the three request channels
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } sol_state_type;

   sol_state_type st_reg;
   sol_state_type st_next;

   logic drive_en;

   ////////////////////////////////////////////////////////////////////////
   // the shared pins hold off their output drivers until capture is done
   assign drive_en = st_reg.locked; // R2

   genvar gi;
   generate
      for (gi = 0; gi < `SOL_PIN_COUNT; gi++) begin : g_pin
         sol_pin_cell u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .drive_en(drive_en),
            .func_val(pin_func_val[gi]),
            .pad_o(pin_o[gi]),
            .pad_oe(pin_oe[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] sol_merge(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : sol_merge

   function automatic sol_mode_type sol_decode(input logic [2:0] code);
      sol_mode_type m;
      if (code == `SOL_MODE_RMII) begin // R7
         m = SOL_MD_RMII;
      end else if (code == `SOL_MODE_B2B) begin
         m = SOL_MD_B2B;
      end else begin
         m = SOL_MD_RSVD;
      end
      return m;
   endfunction : sol_decode

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0] straps;
      logic do_write;
      logic do_read;
      straps = '0;
      do_write = 1'b0;
      do_read = 1'b0;
      st_next = st_reg;

      unique case (st_reg.phase)
         SOL_ST_RESET: begin
            st_next.phase = SOL_ST_CAPTURE;
         end
         SOL_ST_CAPTURE: begin
            // second clock after release: pins still undriven, so the board levels are taken
            st_next.addr_lo = mgmt_addr_strap; // R1 R3
            st_next.bcast_off = bcast_disable_strap; // R6
            st_next.mode_code = mode_strap; // R7
            st_next.nand_n = nand_tree_strap_n; // R12
            // private copies keep the strap word true after software retunes the control bits,
            // which are only seeded from the same levels below
            st_next.iso_cap = iso_strap; // R8
            st_next.speed_cap = speed_strap; // R9
            st_next.duplex_cap = duplex_strap; // R10
            st_next.aneg_cap = autoneg_enable_strap; // R11
            st_next.ctrl = '0;
            st_next.ctrl[`SOL_CTRL_ISO_BIT] = iso_strap; // R8
            st_next.ctrl[`SOL_CTRL_SPEED_BIT] = speed_strap; // R9
            st_next.ctrl[`SOL_CTRL_DUPLEX_BIT] = duplex_strap; // R10
            st_next.ctrl[`SOL_CTRL_ANEG_BIT] = autoneg_enable_strap; // R11
            st_next.adv = '0;
            // 100 Mbps capability only when the speed strap is high
            st_next.adv[`SOL_ADV_100_LSB +: 2] = {2{speed_strap}}; // R9
            st_next.adv[`SOL_ADV_10_LSB +: 2] = 2'h3;
            st_next.locked = 1'b1; // R1 R2
            st_next.phase = SOL_ST_RUN;
         end
         SOL_ST_RUN: begin
            st_next.phase = SOL_ST_RUN;
         end
         default: begin
            st_next.phase = SOL_ST_RESET;
         end
      endcase

      // decoded outputs follow captured values and the software override
      st_next.addr_out = {`SOL_ADDR_HIGH, st_reg.addr_lo}; // R4
      st_next.bcast_out = !st_reg.bcast_off && !st_reg.mode_reg[`SOL_MODE_UNIQUE_BIT]; // R5 R6
      st_next.mode_out = sol_decode(st_reg.mode_code);
      st_next.nand_out = st_reg.locked && !st_reg.nand_n; // R12

      // read-only word built from the captured copies only
      straps[`SOL_ST_ADDR_LSB +: 5] = {`SOL_ADDR_HIGH, st_reg.addr_lo};
      straps[`SOL_ST_BCAST_BIT] = st_reg.bcast_off;
      straps[`SOL_ST_MODE_LSB +: 3] = st_reg.mode_code;
      straps[`SOL_ST_ISO_BIT] = st_reg.iso_cap; // R1
      straps[`SOL_ST_SPEED_BIT] = st_reg.speed_cap;
      straps[`SOL_ST_DUPLEX_BIT] = st_reg.duplex_cap;
      straps[`SOL_ST_ANEG_BIT] = st_reg.aneg_cap;
      straps[`SOL_ST_NAND_BIT] = st_reg.nand_n;
      straps[`SOL_ST_LOCKED_BIT] = st_reg.locked;

      // write channel: address and data taken in either order
      if (s_axi_awvalid && st_reg.aw_rdy) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.w_rdy) begin
         st_next.w_have = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      do_write = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
      if (do_write) begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = resp_okay;
         // writes before capture would be overwritten, so they are refused
         if (!st_reg.locked) begin
            st_next.bresp = resp_slverr;
         end else if (st_reg.aw_addr[7:2] == idx_ctrl) begin
            st_next.ctrl = sol_merge(st_reg.ctrl, st_reg.w_data, st_reg.w_strb);
         end else if (st_reg.aw_addr[7:2] == idx_adv) begin
            st_next.adv = sol_merge(st_reg.adv, st_reg.w_data, st_reg.w_strb);
         end else if (st_reg.aw_addr[7:2] == idx_mode) begin
            st_next.mode_reg = sol_merge(st_reg.mode_reg, st_reg.w_data, st_reg.w_strb); // R5
         end else if (st_reg.aw_addr[7:2] != idx_straps) begin
            st_next.bresp = resp_slverr;
         end
      end else if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // read channel: one-cycle accept, answer the next cycle
      do_read = s_axi_arvalid && st_reg.ar_rdy;
      if (do_read) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = resp_okay;
         st_next.rdata = '0;
         unique case (s_axi_araddr[7:2])
            idx_straps: st_next.rdata = straps;
            idx_ctrl: st_next.rdata = {16'h0000, st_reg.ctrl};
            idx_adv: st_next.rdata = {16'h0000, st_reg.adv};
            idx_mode: st_next.rdata = {16'h0000, st_reg.mode_reg};
            default: st_next.rresp = resp_slverr;
         endcase
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end

      // readies are flops so every bus output leaves a register; they stay low through reset
      // and rise on the first clock after it, which costs no throughput with one item in flight
      st_next.aw_rdy = !st_next.aw_have && !st_next.bvalid;
      st_next.w_rdy = !st_next.w_have && !st_next.bvalid;
      st_next.ar_rdy = !st_next.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign mgmt_addr = st_reg.addr_out;
   assign addr0_broadcast = st_reg.bcast_out;
   assign op_mode = st_reg.mode_out;
   assign nand_tree_en = st_reg.nand_out;
   assign strap_locked = st_reg.locked;
   // every output below is a register field
   assign s_axi_awready = st_reg.aw_rdy;
   assign s_axi_wready = st_reg.w_rdy;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.ar_rdy;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
endmodule : sol_strap_latch

// file: verification/sol_strap_board.sv
module sol_strap_board (
   // resistor levels chosen by the bench
   input wire logic [12:0] levels,
   // device pad drive
   input wire logic [12:0] pin_o,
   input wire logic [12:0] pin_oe,
   // resolved strap nets
   output logic [12:0] pad
);
   timeunit 1ns;
   timeprecision 1ns;
   // the attached mac stays off the pins while reset holds, so only resistors set the captured level
   always_comb begin
      for (int k = 0; k < 13; k++) begin
         pad[k] = pin_oe[k] ? pin_o[k] : levels[k];
      end
   end
endmodule : sol_strap_board

// file: verification/sol_strap_latch_props.sv
module sol_strap_latch_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // straps and pins
   input wire logic [2:0] mgmt_addr_strap,
   input wire logic bcast_disable_strap,
   input wire logic [2:0] mode_strap,
   input wire logic nand_tree_strap_n,
   input wire logic [12:0] pin_func_val,
   input wire logic [12:0] pin_o,
   input wire logic [12:0] pin_oe,
   // decoded configuration
   input wire logic [4:0] mgmt_addr,
   input wire logic addr0_broadcast,
   input wire logic [1:0] op_mode,
   input wire logic nand_tree_en,
   input wire logic strap_locked
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////
   chk_no_drive_early: assert property (!strap_locked |-> pin_oe == 13'h0000)
      else $error("pins driven before straps locked");
   chk_drive_after: assert property ($rose(strap_locked) |=> pin_oe == 13'h1FFF)
      else $error("pins not turned to outputs");
   chk_pin_follows: assert property (pin_oe[0] |-> pin_o == $past(pin_func_val))
      else $error("pad output does not follow function value");
   chk_addr_upper: assert property (mgmt_addr[4:3] == 2'h0)
      else $error("upper address bits not zero");
   chk_addr_capture: assert property ($rose(strap_locked) |=> mgmt_addr[2:0] == $past(mgmt_addr_strap))
      else $error("address not captured");
   chk_mode_decode: assert property ($rose(strap_locked) |=>
      op_mode == (($past(mode_strap) == 3'h1) ? 2'h0 : ($past(mode_strap) == 3'h5) ? 2'h1 : 2'h2))
      else $error("mode decode wrong");
   chk_nand_capture: assert property ($rose(strap_locked) |=> nand_tree_en == !$past(nand_tree_strap_n))
      else $error("test mode capture wrong");
   chk_bcast_capture: assert property ($rose(strap_locked) |=> addr0_broadcast == !$past(bcast_disable_strap))
      else $error("broadcast capture wrong");
   chk_held_values: assert property (strap_locked && $past(strap_locked) |=>
      strap_locked && $stable(mgmt_addr) && $stable(op_mode) && $stable(nand_tree_en))
      else $error("captured values changed");
   ////////////////////////////////////////////////////////////////
   cov_lock: cover property ($rose(strap_locked));
   cov_b2b: cover property (strap_locked && op_mode == 2'h1);
   cov_unique: cover property (strap_locked && $fell(addr0_broadcast));
endmodule : sol_strap_latch_props

bind sol_strap_latch sol_strap_latch_props sol_strap_latch_props_inst (
   .aclk(aclk), .aresetn(aresetn), .mgmt_addr_strap(mgmt_addr_strap),
   .bcast_disable_strap(bcast_disable_strap), .mode_strap(mode_strap), .nand_tree_strap_n(nand_tree_strap_n),
   .pin_func_val(pin_func_val), .pin_o(pin_o), .pin_oe(pin_oe), .mgmt_addr(mgmt_addr),
   .addr0_broadcast(addr0_broadcast), .op_mode(op_mode), .nand_tree_en(nand_tree_en),
   .strap_locked(strap_locked)
);

// file: verification/sol_strap_latch_tb_top.sv
module sol_strap_latch_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [12:0] lv = 13'h0F11;
   logic [12:0] pin_func_val = 13'h0000;
   logic [12:0] pad, pin_o, pin_oe;
   logic [4:0] mgmt_addr;
   logic [1:0] op_mode, s_axi_bresp, s_axi_rresp, rsp;
   logic addr0_broadcast, nand_tree_en, strap_locked;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   // level vector: addr 2:0, bcast 3, mode 6:4, iso 7, speed 8, duplex 9, aneg 10, nand 11
   wire logic [2:0] mgmt_addr_strap = pad[2:0];
   wire logic bcast_disable_strap = pad[3];
   wire logic [2:0] mode_strap = pad[6:4];
   wire logic iso_strap = pad[7];
   wire logic speed_strap = pad[8];
   wire logic duplex_strap = pad[9];
   wire logic autoneg_enable_strap = pad[10];
   wire logic nand_tree_strap_n = pad[11];
   int mismatches = 0;
   int checks = 0;
   always #20 aclk = ~aclk;
   sol_strap_latch sol_strap_latch_inst (
      .aclk(aclk), .aresetn(aresetn), .mgmt_addr_strap(mgmt_addr_strap),
      .bcast_disable_strap(bcast_disable_strap), .mode_strap(mode_strap), .iso_strap(iso_strap),
      .speed_strap(speed_strap), .duplex_strap(duplex_strap), .autoneg_enable_strap(autoneg_enable_strap),
      .nand_tree_strap_n(nand_tree_strap_n), .pin_func_val(pin_func_val), .pin_o(pin_o), .pin_oe(pin_oe),
      .mgmt_addr(mgmt_addr), .addr0_broadcast(addr0_broadcast), .op_mode(op_mode),
      .nand_tree_en(nand_tree_en), .strap_locked(strap_locked),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );
   sol_strap_board sol_strap_board_inst (.levels(lv), .pin_o(pin_o), .pin_oe(pin_oe), .pad(pad));
   ////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // one idle edge keeps a following call from reassigning the same strobe in this time step
      @(posedge aclk);
      if (n == 40) begin mismatches++; stop_test(); end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
      if (n == 40) begin mismatches++; stop_test(); end
   endtask : axi_rd
   function automatic logic [31:0] exp_straps(input logic [12:0] v);
      return {1'b1, 14'h0, v[11:7], 1'b0, v[6:4], 2'h0, v[3], 2'h0, v[2:0]};
   endfunction : exp_straps
   function automatic logic [1:0] exp_mode(input logic [2:0] m);
      return (m == 3'h1) ? 2'h0 : (m == 3'h5) ? 2'h1 : 2'h2;
   endfunction : exp_mode
   ////////////////////////////////////////////////////////////////
   initial begin
      int i;
      int n;
      logic [31:0] wd;
      void'($urandom(32'h40af989d));
      // every mode code once; pass 1 keeps all board defaults
      for (i = 0; i < 8; i++) begin
         @(posedge aclk);
         lv <= (i == 1) ? 13'h0F11 : ((13'($urandom()) & 13'h1F8F) | 13'(i << 4));
         pin_func_val <= 13'($urandom());
         aresetn <= 1'b0;
         repeat (6) @(posedge aclk);
         aresetn <= 1'b1;
         for (n = 0; n < 20 && strap_locked !== 1'b1; n++) @(posedge aclk);
         if (n == 20) begin mismatches++; stop_test(); end
         repeat (2) @(posedge aclk);
         chk(32'(mgmt_addr), {29'h0, lv[2:0]});
         chk(32'(op_mode), 32'(exp_mode(lv[6:4])));
         chk(32'(nand_tree_en), 32'(!lv[11]));
         chk(32'(addr0_broadcast), 32'(!lv[3]));
         chk(32'(pin_oe), 32'h1FFF);
         axi_rd(8'h04);
         chk(rd, {18'h0, lv[8], lv[10], 1'b0, lv[7], 1'b0, lv[9], 8'h00});
         axi_rd(8'h08);
         chk(rd, {23'h0, lv[8], lv[8], 2'h3, 5'h00});
         // software retunes the control bits; the captured word must not follow them
         wd = $urandom();
         axi_wr(8'h04, wd);
         axi_rd(8'h04);
         chk(rd, {16'h0000, wd[15:0]});
         // the read-only word must survive a write and the pads now carrying outputs
         axi_wr(8'h00, $urandom());
         chk(32'(rsp), 32'h0);
         axi_rd(8'h00);
         chk(rd, exp_straps(lv));
         axi_wr(8'h0C, 32'h0200);
         repeat (2) @(posedge aclk);
         chk(32'(addr0_broadcast), 32'h0);
         axi_rd(8'h10);
         chk(32'(rsp), 32'h2);
         axi_wr(8'h10, wd);
         chk(32'(rsp), 32'h2);
         $display("test %0d done", i);
      end
      stop_test();
   end
endmodule : sol_strap_latch_tb_top
